// >>> hw/brs_backup_reset_regs.sv
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "brs_map.svh"

// Notes on behaviour
// - Sleep gate bit 1 keeps a peripheral clock running in sleep.
// - Backup control bits clear only on backup domain reset.
// - Protected backup bits are written only while backup write unlock is high; the backup reset bit clears them with or without it.
// - Backup reset bit holds the whole backup domain in reset.
// - RTC clock gate bit passes or stops the selected RTC clock.
// - RTC source: none, slow crystal, internal oscillator, divided fast crystal.
// - A nonzero RTC source stays fixed until backup domain reset.
// - Two bits set slow crystal drive, zero after backup reset.
// - Bypass bit feeds an external clock instead of the crystal.
// - Slow crystal enable bit; stable flag follows the oscillator.
// - Each reset kind sets its own sticky cause flag.
// - Writing one to the clear bit wipes all seven flags.
// - Flags reset by power reset; clear and osc enable by system.
// - Internal oscillator enable bit; stable flag follows that oscillator.
// - Spread spectrum drives only the main PLL.
// - Spread on bit turns main PLL modulation on or off.
// - Profile bit picks centre spread or down spread.
module brs_backup_reset_regs (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic POR_N,
  input wire logic BKP_POR_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic BACKUP_WRITE_UNLOCK,
  input wire logic SLEEP_MODE,
  input wire logic [6:0] RESET_CAUSE,
  input wire logic SLOW_XTAL_READY,
  input wire logic INT_SLOW_OSC_READY,
  input wire logic SLOW_CRYSTAL_CLOCK,
  input wire logic INTERNAL_SLOW_OSC_CLOCK,
  input wire logic FAST_CRYSTAL_DIV_CLOCK,
  output logic [31:0] PERIPH_CLK_RUN,
  output brs_pkg::brs_backup_s BACKUP_CTRL,
  output logic BACKUP_DOMAIN_RESET,
  output logic INTERNAL_SLOW_OSC_ENABLE,
  output brs_pkg::brs_spread_s MAIN_PLL_SPREAD,
  output logic RTC_CLOCK
);
  import brs_pkg::*;

  brs_wr_state_e wr_state;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] sleep_gates;
  logic [31:0] next_run;
  brs_backup_s bkp;
  logic [6:0] cause_flags;
  logic flags_clr;
  logic osc_en;
  brs_spread_s spread;
  logic [1:0] rdy_meta;
  logic [1:0] rdy_sync;
  logic [31:0] gate_read;
  logic [31:0] bd_read;
  logic [31:0] rc_read;
  logic [31:0] ss_read;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic wr_hit;
  logic gate_wr;
  logic bd_wr;
  logic rc_wr;
  logic ss_wr;
  logic flags_clr_pulse;
  logic [31:0] gate_word;
  logic [31:0] bd_word;
  logic [31:0] rc_word;
  logic [31:0] ss_word;

  // Byte-lane merge of a write into the current register value
  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] m;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return (old & ~m) | (data & m);
  endfunction

  // Word-aligned register decode
  function automatic logic addr_hit(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return (w == `BRS_OFS_SLEEP_GATES) || (w == `BRS_OFS_BDCTL) ||
      (w == `BRS_OFS_RSTCK) || (w == `BRS_OFS_SSCTL);
  endfunction

  // Write channel handshake; address and data taken in either order
  assign S_AXI_AWREADY = (wr_state == BRS_WR_COLLECT) & ~aw_held;
  assign S_AXI_WREADY = (wr_state == BRS_WR_COLLECT) & ~w_held;
  assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_take = S_AXI_WVALID & S_AXI_WREADY;
  assign wr_fire = (wr_state == BRS_WR_COLLECT) &
    (aw_held | aw_take) & (w_held | w_take);
  assign wr_addr = aw_held ? aw_addr_q : S_AXI_AWADDR;
  assign wr_data = w_held ? w_data_q : S_AXI_WDATA;
  assign wr_strb = w_held ? w_strb_q : S_AXI_WSTRB;
  assign wr_hit = addr_hit(wr_addr);

  // Write channel state and response
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_state <= BRS_WR_COLLECT;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `BRS_RESP_OKAY;
    end else begin
      case (wr_state)
        BRS_WR_COLLECT: begin
          if (wr_fire) begin
            wr_state <= BRS_WR_RESP;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? `BRS_RESP_OKAY : `BRS_RESP_SLVERR;
          end else begin
            if (aw_take) begin
              aw_held <= 1'b1;
              aw_addr_q <= S_AXI_AWADDR;
            end
            if (w_take) begin
              w_held <= 1'b1;
              w_data_q <= S_AXI_WDATA;
              w_strb_q <= S_AXI_WSTRB;
            end
          end
        end
        BRS_WR_RESP: begin
          if (S_AXI_BREADY) begin
            wr_state <= BRS_WR_COLLECT;
            S_AXI_BVALID <= 1'b0;
          end
        end
        default: begin
          wr_state <= BRS_WR_COLLECT;
          S_AXI_BVALID <= 1'b0;
        end
      endcase
    end
  end

  // Per-register write strobes and merged words
  assign gate_wr = wr_fire & ({wr_addr[7:2], 2'b00} == `BRS_OFS_SLEEP_GATES);
  assign bd_wr = wr_fire & ({wr_addr[7:2], 2'b00} == `BRS_OFS_BDCTL);
  assign rc_wr = wr_fire & ({wr_addr[7:2], 2'b00} == `BRS_OFS_RSTCK);
  assign ss_wr = wr_fire & ({wr_addr[7:2], 2'b00} == `BRS_OFS_SSCTL);
  assign gate_word = merge_lanes(gate_read, wr_data, wr_strb);
  assign bd_word = merge_lanes(bd_read, wr_data, wr_strb);
  assign rc_word = merge_lanes(rc_read, wr_data, wr_strb);
  assign ss_word = merge_lanes(ss_read, wr_data, wr_strb);
  assign flags_clr_pulse = rc_wr & wr_strb[3] &
    wr_data[`BRS_RC_FLAGS_CLR];

  // Oscillator ready levels come from analog, two-stage synchroniser
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdy_meta <= 2'b00;
      rdy_sync <= 2'b00;
    end else begin
      rdy_meta <= {INT_SLOW_OSC_READY, SLOW_XTAL_READY};
      rdy_sync <= rdy_meta;
    end
  end

  // Sleep gate bits, reserved positions held at zero
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sleep_gates <= `BRS_RST_SLEEP_GATES;
    end else if (gate_wr) begin
      sleep_gates <= gate_word & `BRS_MASK_SLEEP_GATES;
    end
  end

  // Per-peripheral run enable: awake, or gate bit set
  for (genvar i = 0; i < 32; i++) begin : g_run
    assign next_run[i] = ~SLEEP_MODE | sleep_gates[i];
  end

  // Registered run enables
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PERIPH_CLK_RUN <= 32'hffff_ffff;
    end else begin
      PERIPH_CLK_RUN <= next_run;
    end
  end

  // Backup domain: only backup power-up or backup reset bit clears it
  always_ff @(posedge REF_CLK or negedge BKP_POR_N) begin
    if (!BKP_POR_N) begin
      bkp <= '0;
    end else begin
      if (bd_wr) begin
        bkp.bkp_rst <= bd_word[`BRS_BD_BKP_RST];
      end
      if (bkp.bkp_rst) begin
        bkp.rtc_en <= 1'b0;
        bkp.rtc_src <= BRS_RTC_NONE;
        bkp.drive <= 2'b00;
        bkp.bypass <= 1'b0;
        bkp.xtal_en <= 1'b0;
      end else if (bd_wr) begin
        bkp.drive <= bd_word[`BRS_BD_DRIVE_LO +: 2];
        if (BACKUP_WRITE_UNLOCK) begin
          bkp.rtc_en <= bd_word[`BRS_BD_RTC_EN];
          bkp.bypass <= bd_word[`BRS_BD_BYPASS];
          bkp.xtal_en <= bd_word[`BRS_BD_XTAL_EN];
          if (bkp.rtc_src == BRS_RTC_NONE) begin
            bkp.rtc_src <= brs_rtc_src_e'(
              bd_word[`BRS_BD_RTC_SRC_LO +: 2]);
          end
        end
      end
    end
  end

  assign BACKUP_CTRL = bkp;
  assign BACKUP_DOMAIN_RESET = bkp.bkp_rst;

  // Cause flags survive system reset; new causes beat a clear
  always_ff @(posedge REF_CLK or negedge POR_N) begin
    if (!POR_N) begin
      cause_flags <= `BRS_RST_CAUSE;
    end else begin
      cause_flags <= (cause_flags & ~{7{flags_clr_pulse}}) |
        RESET_CAUSE;
    end
  end

  // Clear bit and internal oscillator enable on system reset
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_clr <= 1'b0;
      osc_en <= 1'b0;
    end else if (rc_wr) begin
      flags_clr <= rc_word[`BRS_RC_FLAGS_CLR];
      osc_en <= rc_word[`BRS_RC_OSC_EN];
    end
  end

  assign INTERNAL_SLOW_OSC_ENABLE = osc_en;

  // Spread spectrum settings; software keeps PLL off while writing
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      spread <= '0;
    end else if (ss_wr) begin
      spread.on <= ss_word[`BRS_SS_ON];
      spread.down <= ss_word[`BRS_SS_DOWN];
      spread.step <= ss_word[`BRS_SS_STEP_LO +: 15];
      spread.count <= ss_word[`BRS_SS_CNT_LO +: 13];
    end
  end

  // Only the main PLL sees the modulation settings
  assign MAIN_PLL_SPREAD = spread;

  // Read-back words, reserved bits zero
  always_comb begin
    gate_read = sleep_gates;
    bd_read = 32'h0000_0000;
    bd_read[`BRS_BD_BKP_RST] = bkp.bkp_rst;
    bd_read[`BRS_BD_RTC_EN] = bkp.rtc_en;
    bd_read[`BRS_BD_RTC_SRC_LO +: 2] = bkp.rtc_src;
    bd_read[`BRS_BD_DRIVE_LO +: 2] = bkp.drive;
    bd_read[`BRS_BD_BYPASS] = bkp.bypass;
    bd_read[`BRS_BD_XTAL_STB] = rdy_sync[0];
    bd_read[`BRS_BD_XTAL_EN] = bkp.xtal_en;
    rc_read = 32'h0000_0000;
    rc_read[`BRS_RC_FLAGS_LO +: 7] = cause_flags;
    rc_read[`BRS_RC_FLAGS_CLR] = flags_clr;
    rc_read[`BRS_RC_OSC_STB] = rdy_sync[1];
    rc_read[`BRS_RC_OSC_EN] = osc_en;
    ss_read = 32'h0000_0000;
    ss_read[`BRS_SS_ON] = spread.on;
    ss_read[`BRS_SS_DOWN] = spread.down;
    ss_read[`BRS_SS_STEP_LO +: 15] = spread.step;
    ss_read[`BRS_SS_CNT_LO +: 13] = spread.count;
  end

  // Read address decode
  always_comb begin
    rd_hit = 1'b1;
    case ({S_AXI_ARADDR[7:2], 2'b00})
      `BRS_OFS_SLEEP_GATES: rd_mux = gate_read;
      `BRS_OFS_BDCTL: rd_mux = bd_read;
      `BRS_OFS_RSTCK: rd_mux = rc_read;
      `BRS_OFS_SSCTL: rd_mux = ss_read;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  // Read channel, one cycle from address to data
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `BRS_RESP_OKAY;
    end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_mux;
      S_AXI_RRESP <= rd_hit ? `BRS_RESP_OKAY : `BRS_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // RTC clock selection and gate
  brs_rtc_clock_gate u_rtc_gate (
    .sel(bkp.rtc_src),
    .en(bkp.rtc_en),
    .slow_crystal_clock(SLOW_CRYSTAL_CLOCK),
    .internal_slow_osc_clock(INTERNAL_SLOW_OSC_CLOCK),
    .fast_crystal_div_clock(FAST_CRYSTAL_DIV_CLOCK),
    .rtc_clock(RTC_CLOCK)
  );

  // Checks on the register behaviour
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  chk_sleep_gate_run: assert property (
    SLEEP_MODE |=> PERIPH_CLK_RUN == $past(sleep_gates))
    else $error("run enable does not follow sleep gate");

  chk_locked_bits_hold: assert property (
    bd_wr && !BACKUP_WRITE_UNLOCK && !bkp.bkp_rst && BKP_POR_N |=>
    $stable(bkp.xtal_en) && $stable(bkp.rtc_en) && $stable(bkp.bypass))
    else $error("protected backup bit changed while locked");

  chk_backup_reset_clear: assert property (
    bkp.bkp_rst |=> bkp.rtc_src == BRS_RTC_NONE && !bkp.xtal_en &&
    bkp.drive == 2'b00 && !bkp.rtc_en)
    else $error("backup reset did not clear backup bits");

  chk_rtc_gate_off: assert property (
    !bkp.rtc_en |-> !RTC_CLOCK)
    else $error("rtc clock runs while gated");

  chk_source_locked: assert property (
    BKP_POR_N && !bkp.bkp_rst && bkp.rtc_src != BRS_RTC_NONE |=>
    !BKP_POR_N || $stable(bkp.rtc_src))
    else $error("rtc source changed after selection");

  chk_xtal_stable_flag: assert property (
    SLOW_XTAL_READY [*4] |-> bd_read[`BRS_BD_XTAL_STB])
    else $error("slow crystal stable flag missing");

  chk_cause_sticky: assert property (
    POR_N && |RESET_CAUSE |=>
    (cause_flags & $past(RESET_CAUSE)) == $past(RESET_CAUSE))
    else $error("reset cause flag not set");

  chk_flags_cleared: assert property (
    POR_N && flags_clr_pulse && RESET_CAUSE == 7'h00 |=>
    cause_flags == 7'h00)
    else $error("reset cause flags not cleared");

  chk_spread_on_write: assert property (
    ss_wr && wr_strb[3] |=>
    MAIN_PLL_SPREAD.on == $past(wr_data[`BRS_SS_ON]))
    else $error("spread on bit not taken");

  cov_unlocked_bd_write: cover property (bd_wr && BACKUP_WRITE_UNLOCK);
  cov_source_selected: cover property (
    bkp.rtc_src == BRS_RTC_NONE ##1 bkp.rtc_src != BRS_RTC_NONE);
  cov_flags_cleared: cover property (flags_clr_pulse);
  cov_bad_read: cover property (S_AXI_RVALID && !rd_hit);

endmodule

// >>> hw/brs_map.svh
`ifndef BRS_MAP_SVH
`define BRS_MAP_SVH

// Register byte offsets
`define BRS_OFS_SLEEP_GATES 8'h64
`define BRS_OFS_BDCTL 8'h70
`define BRS_OFS_RSTCK 8'h74
`define BRS_OFS_SSCTL 8'h80

// Reset values and writable masks
`define BRS_RST_SLEEP_GATES 32'h0477_7f33
`define BRS_MASK_SLEEP_GATES 32'h0477_7f33
`define BRS_RST_RSTCK 32'h0e00_0000
`define BRS_RST_CAUSE 7'h07

// Backup domain control fields
`define BRS_BD_BKP_RST 16
`define BRS_BD_RTC_EN 15
`define BRS_BD_RTC_SRC_LO 8
`define BRS_BD_DRIVE_LO 3
`define BRS_BD_BYPASS 2
`define BRS_BD_XTAL_STB 1
`define BRS_BD_XTAL_EN 0

// Reset cause and slow oscillator fields
`define BRS_RC_FLAGS_LO 25
`define BRS_RC_FLAGS_CLR 24
`define BRS_RC_OSC_STB 1
`define BRS_RC_OSC_EN 0

// Spread spectrum control fields
`define BRS_SS_ON 31
`define BRS_SS_DOWN 30
`define BRS_SS_STEP_LO 13
`define BRS_SS_CNT_LO 0

// Bus answers
`define BRS_RESP_OKAY 2'b00
`define BRS_RESP_SLVERR 2'b10

`endif

// >>> hw/brs_pkg.sv
package brs_pkg;

  typedef enum logic [1:0] {
    BRS_RTC_NONE = 2'b00,
    BRS_RTC_SLOW_XTAL = 2'b01,
    BRS_RTC_INT_OSC = 2'b10,
    BRS_RTC_FAST_DIV = 2'b11
  } brs_rtc_src_e;

  typedef enum logic [0:0] {
    BRS_WR_COLLECT = 1'b0,
    BRS_WR_RESP = 1'b1
  } brs_wr_state_e;

  typedef struct packed {
    logic bkp_rst;
    logic rtc_en;
    brs_rtc_src_e rtc_src;
    logic [1:0] drive;
    logic bypass;
    logic xtal_en;
  } brs_backup_s;

  typedef struct packed {
    logic on;
    logic down;
    logic [14:0] step;
    logic [12:0] count;
  } brs_spread_s;

endpackage

// >>> hw/brs_rtc_clock_gate.sv
`timescale 1ns/1ps

module brs_rtc_clock_gate (
  input wire logic [1:0] sel,
  input wire logic en,
  input wire logic slow_crystal_clock,
  input wire logic internal_slow_osc_clock,
  input wire logic fast_crystal_div_clock,
  output logic rtc_clock
);
  import brs_pkg::*;

  // Source mux; select moves only on first selection from none or at backup reset, so no glitch guard
  always_comb begin
    case (brs_rtc_src_e'(sel))
      BRS_RTC_NONE: rtc_clock = 1'b0;
      BRS_RTC_SLOW_XTAL: rtc_clock = en & slow_crystal_clock;
      BRS_RTC_INT_OSC: rtc_clock = en & internal_slow_osc_clock;
      BRS_RTC_FAST_DIV: rtc_clock = en & fast_crystal_div_clock;
      default: rtc_clock = 1'b0;
    endcase
  end

endmodule

// >>> verif/tb_rcu_backup_reset_sscg_regs.sv
`timescale 1ns/1ps
`include "brs_map.svh"

module tb_rcu_backup_reset_sscg_regs;
  import brs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic bpor_n = 1'b0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic unlock = 1'b0;
  logic sleep = 1'b0;
  logic [6:0] cause = 7'h0;
  logic xrdy = 1'b0;
  logic ordy = 1'b0;
  logic cs = 1'b0;
  logic ci = 1'b0;
  logic cf = 1'b0;
  logic [3:0] dv = 4'h0;
  logic [3:0] strb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, bkrst, oscen, rtc;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, run;
  brs_backup_s bk;
  brs_spread_s ss;
  logic [15:0] lf = 16'he3ba;
  int error_cnt = 0;
  int n_tests = 0;
  localparam logic [31:0] GM = `BRS_MASK_SLEEP_GATES;

  brs_backup_reset_regs dut_u (
    .REF_CLK(clk), .RST_N(rst_n), .POR_N(por_n), .BKP_POR_N(bpor_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .BACKUP_WRITE_UNLOCK(unlock),
    .SLEEP_MODE(sleep), .RESET_CAUSE(cause), .SLOW_XTAL_READY(xrdy),
    .INT_SLOW_OSC_READY(ordy), .SLOW_CRYSTAL_CLOCK(cs),
    .INTERNAL_SLOW_OSC_CLOCK(ci), .FAST_CRYSTAL_DIV_CLOCK(cf),
    .PERIPH_CLK_RUN(run), .BACKUP_CTRL(bk), .BACKUP_DOMAIN_RESET(bkrst),
    .INTERNAL_SLOW_OSC_ENABLE(oscen), .MAIN_PLL_SPREAD(ss),
    .RTC_CLOCK(rtc)
  );

  // Bench clock
  always #5 clk = ~clk;

  // Three distinct slow source patterns for the RTC mux
  always @(posedge clk) begin
    dv <= dv + 4'h1;
    cs <= ~cs;
    ci <= dv[1];
    cf <= dv[2];
  end

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] rnd();
    lf = step(lf);
    rnd[31:16] = lf;
    lf = step(lf);
    rnd[15:0] = lf;
  endfunction

  // Keep step times count within the allowed product
  function automatic logic [31:0] ss_legal(input logic [31:0] d);
    int c;
    int s;
    c = int'(d[12:0]) | 1;
    s = int'(d[27:13]) % (32767 / c + 1);
    return {d[31:28], s[14:0], c[12:0]};
  endfunction

  task automatic stop_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic pa, pw, pb, ha, hw, hb;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pb) begin
      @(negedge clk);
      ha = awready;
      hw = wready;
      hb = bvalid;
      r = bresp;
      @(posedge clk);
      if (pa && ha) awvalid <= 1'b0;
      if (pw && hw) wvalid <= 1'b0;
      pa = pa && !ha;
      pw = pw && !hw;
      if (hb) bready <= 1'b0;
      pb = !hb;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic pa, ha, hv;
    pa = 1'b1;
    hv = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hv) begin
      @(negedge clk);
      ha = arready;
      hv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (pa && ha) arvalid <= 1'b0;
      pa = pa && !ha;
      if (hv) rready <= 1'b0;
    end
  endtask

  // Write expecting an OKAY answer
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, 32'h0);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask

  // RTC output against the expected source over eight cycles
  task automatic rtc_chk(input logic [1:0] s);
    logic e;
    repeat (8) begin
      @(negedge clk);
      e = (s == 2'h1) ? cs : (s == 2'h2) ? ci : (s == 2'h3) ? cf : 1'b0;
      chk({31'h0, rtc}, {31'h0, e});
    end
  endtask

  task automatic rst_pulse(input logic [2:0] m);
    @(posedge clk);
    {rst_n, por_n, bpor_n} <= ~m;
    repeat (2) @(posedge clk);
    {rst_n, por_n, bpor_n} <= 3'h7;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("Error at %0t: timeout", $time);
    stop_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (20) @(posedge clk);
    {rst_n, por_n, bpor_n} <= 3'h7;
    rc(8'h64, `BRS_RST_SLEEP_GATES);
    rc(8'h70, 32'h0);
    rc(8'h74, `BRS_RST_RSTCK);
    rc(8'h80, 32'h0);
    chk(run, 32'hffffffff);
    // Stable flags follow the oscillator ready inputs
    xrdy <= 1'b1;
    ordy <= 1'b1;
    repeat (4) @(posedge clk);
    rc(8'h70, 32'h2);
    rc(8'h74, 32'h0e000002);
    xrdy <= 1'b0;
    repeat (4) @(posedge clk);
    rc(8'h70, 32'h0);
    // Unmapped places
    rd(8'h10, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, `BRS_RESP_SLVERR});
    wr(8'h90, 32'hffffffff, r);
    chk({30'h0, r}, {30'h0, `BRS_RESP_SLVERR});
    // Sleep gates with corners and random words
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : rnd();
      wrt(8'h64, d);
      rc(8'h64, d & GM);
      sleep <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(run, d & GM);
      @(posedge clk);
      sleep <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(run, 32'hffffffff);
    end
    // Spread control word; main PLL held off, legal step and count
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hcfffffff : (i == 1) ? 32'h0fffe001 : rnd();
      d = ss_legal(d);
      wrt(8'h80, d);
      rc(8'h80, d & 32'hcfffffff);
      chk({2'h0, ss}, {2'h0, d[31:30], d[27:0]});
    end
    // Protected backup bits against the unlock input
    wrt(8'h70, 32'h0000811d);
    rc(8'h70, 32'h00000018);
    unlock <= 1'b1;
    wrt(8'h70, 32'h0000811d);
    rc(8'h70, 32'h0000811d);
    chk({24'h0, bk}, 32'h0000005f);
    rtc_chk(2'h1);
    wrt(8'h70, 32'h0000821d);
    rc(8'h70, 32'h0000811d);
    wrt(8'h70, 32'h0000011d);
    rtc_chk(2'h0);
    unlock <= 1'b0;
    wrt(8'h70, 32'h0);
    rc(8'h70, 32'h00000105);
    unlock <= 1'b1;
    // Each source code after a software backup reset
    for (int s = 1; s < 4; s++) begin
      wrt(8'h70, 32'h00010000);
      chk({31'h0, bkrst}, 32'h1);
      rc(8'h70, 32'h00010000);
      wrt(8'h70, 32'h0);
      chk({31'h0, bkrst}, 32'h0);
      d = 32'h00008000 | (32'(s) << 8);
      wrt(8'h70, d);
      rc(8'h70, d);
      rtc_chk(s[1:0]);
    end
    // System reset spares the backup bits
    rst_pulse(3'h4);
    rc(8'h70, 32'h00008300);
    rc(8'h64, `BRS_RST_SLEEP_GATES);
    rc(8'h80, 32'h0);
    rst_pulse(3'h1);
    rc(8'h70, 32'h0);
    rtc_chk(2'h0);
    // Reset cause flags, one per kind
    wrt(8'h74, 32'h01000000);
    rc(8'h74, 32'h01000002);
    for (int i = 0; i < 7; i++) begin
      wrt(8'h74, 32'h00000001);
      cause <= 7'(1 << i);
      @(posedge clk);
      cause <= 7'h0;
      wrt(8'h74, 32'h00000001);
      rc(8'h74, (32'h1 << (25 + i)) | 32'h3);
      chk({31'h0, oscen}, 32'h1);
      wrt(8'h74, 32'h01000001);
      rc(8'h74, 32'h01000003);
    end
    wrt(8'h74, 32'h00000001);
    cause <= 7'h08;
    @(posedge clk);
    cause <= 7'h0;
    // Clear bit outside the written lanes leaves the flags
    strb <= 4'h7;
    wrt(8'h74, 32'h01000001);
    strb <= 4'hf;
    rc(8'h74, 32'h10000003);
    wrt(8'h74, 32'h01000001);
    cause <= 7'h08;
    @(posedge clk);
    cause <= 7'h0;
    wrt(8'h74, 32'h00000001);
    rst_pulse(3'h4);
    // Stable flag passes the synchroniser again after system reset
    repeat (2) @(posedge clk);
    rc(8'h74, 32'h10000002);
    chk({31'h0, oscen}, 32'h0);
    rst_pulse(3'h2);
    rc(8'h74, 32'h0e000002);
    stop_test();
  end
endmodule
